// ===== hw/dbg_consts.svh
// dbg_consts.svh: offsets, fields and reset values of the debug bank.
// assumes: included by its bare name.
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

`define DBG_MODULE          4'h2
`define DBG_IDX_SCRATCH0    5'h18
`define DBG_IDX_SCRATCH1    5'h19
`define DBG_IDX_CONTROL     5'h1a
`define DBG_IDX_FLAGS       5'h1b
`define DBG_IDX_BUFFER      5'h1c

`define DBG_CTL_BPEN_BIT    7
`define DBG_CTL_REGBRK_BIT  5
`define DBG_CTL_CMD_MSB     3
`define DBG_CTL_WMASK       8'haf

`define DBG_FLG_PSS_MSB     3
`define DBG_FLG_PSS_LSB     2
`define DBG_FLG_SPE_BIT     1
`define DBG_FLG_XFER_BIT    0
`define DBG_FLG_WMASK       8'h0f

`define DBG_RESET_WORD      16'h0000
`define DBG_RESET_BYTE      8'h00

`endif

// ===== hw/dbg_pkg.sv
// dbg_pkg: types shared by the debug register bank.
// assumes: compiled before every design module.
package dbg_pkg;

    typedef enum logic [3:0] {
        cmd_nop        = 4'b0000,
        cmd_read_map   = 4'b0001,
        cmd_read_data  = 4'b0010,
        cmd_read_stack = 4'b0011,
        cmd_write_reg  = 4'b0100,
        cmd_write_data = 4'b0101,
        cmd_single_stp = 4'b0110,
        cmd_unlock     = 4'b1000,
        cmd_read_reg   = 4'b1001
    } host_cmd_type;

endpackage : dbg_pkg

// ===== hw/break_match.sv
// break_match: breakpoint-4/5 register compare, gated by breakpoint enable.
// assumes: all inputs on mclk; outputs are registered.
`timescale 1ns/1ns
module break_match #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             tap_reset,
    // control
    input  wire logic             breakpoint_enable,
    input  wire logic             register_break_select,
    // instruction writeback
    input  wire logic             dest_write,
    input  wire logic [7:0]       dest_addr,
    input  wire logic [WIDTH-1:0] dest_data,
    input  wire logic [7:0]       breakpoint_four,
    input  wire logic [7:0]       breakpoint_five,
    input  wire logic [WIDTH-1:0] break_mask_register,
    input  wire logic [WIDTH-1:0] break_compare_register,
    // hits
    output logic                  hit_four,
    output logic                  hit_five
);
    logic [WIDTH-1:0] bit_ok;
    logic             arm;
    logic             four_d;
    logic             five_d;
    logic             hit_four_q;
    logic             hit_five_q;

    // masked-off bits always agree, so an all-zero mask hits on any data
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_cmp
            assign bit_ok[g] = ~break_mask_register[g] |
                (dest_data[g] == break_compare_register[g]);
        end
    endgenerate

    assign arm    = breakpoint_enable & register_break_select & dest_write;
    assign four_d = arm & (dest_addr == breakpoint_four);
    assign five_d = arm & (dest_addr == breakpoint_five) & (&bit_ok);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hit_four_q <= 1'b0;
            hit_five_q <= 1'b0;
        end else if (tap_reset) begin
            hit_four_q <= 1'b0;
            hit_five_q <= 1'b0;
        end else begin
            hit_four_q <= four_d;
            hit_five_q <= five_d;
        end
    end

    assign hit_four = hit_four_q;
    assign hit_five = hit_five_q;
endmodule : break_match

// ===== hw/xfer_sync.sv
// xfer_sync: brings the tap's transfer-done toggle into mclk as a pulse.
// assumes: toggle comes from the test clock domain.
`timescale 1ns/1ns
module xfer_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // foreign toggle
    input  wire logic toggle_in,
    // local pulse
    output logic      done_pulse
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= toggle_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign done_pulse = sync_q ^ last_q;
endmodule : xfer_sync

// ===== hw/debug_engine_register_bank.sv
// What this block does
// - registers reached at module 02h by index
// - scratch access only in background/debug mode
// - scratch and control clear on reset, tlr
// - control written only by debug engine
// - bit 7 enables breakpoints, background always works
// - breakpoint enable changes only in debug mode
// - control bits 6 and 4 read zero
// - register break: bp4 matches destination address
// - bp5 needs address and masked data match
// - no break unless breakpoint enable set
// - engine loads serviced command into bits 3:0, in debug mode only
// - command field uses fixed encoding
// - flag bits 7:4 read zero, writes dropped
// - source select and program enable read/write
// - transfer flag set at tap transfer end
// - rom sets transfer flag, engine clears
// - cpu write to transfer clears source select
// - 8-bit buffer exchanged with tap shift register
// - buffer clears on reset and tlr
// - runs on system clock, halted in stop
// - host commands decoded from buffer byte
// - bp5 mask selects compared data bits
//
// debug_engine_register_bank: debug engine peripheral registers.
// assumes: cpu bus on mclk; tap gives a scan toggle, tap_reset, byte.
`timescale 1ns/1ns
`include "dbg_consts.svh"
module debug_engine_register_bank #(
    parameter int DATA_WIDTH = 16
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  stop_mode,
    // cpu peripheral access
    input  wire logic [3:0]            cpu_module,
    input  wire logic [4:0]            cpu_index,
    input  wire logic                  cpu_read,
    input  wire logic                  cpu_write,
    input  wire logic [DATA_WIDTH-1:0] cpu_wdata,
    output logic      [DATA_WIDTH-1:0] cpu_rdata,
    // debug mode status
    input  wire logic                  background_mode,
    input  wire logic                  debug_mode,
    // tap side
    input  wire logic                  tap_reset,
    input  wire logic                  tap_xfer_toggle,
    input  wire logic [7:0]            tap_shift_in,
    output logic      [7:0]            tap_shift_out,
    // debug engine side
    input  wire logic                  eng_ctl_write,
    input  wire logic [7:0]            eng_ctl_data,
    input  wire logic                  eng_cmd_load,
    input  wire logic                  eng_xfer_clear,
    input  wire logic                  eng_flag_write,
    input  wire logic [7:0]            eng_flag_data,
    input  wire logic                  eng_buf_write,
    input  wire logic [7:0]            eng_buf_data,
    input  wire logic [15:0]           break_mask_register,
    input  wire logic [15:0]           break_compare_register,
    input  wire logic [7:0]            breakpoint_four,
    input  wire logic [7:0]            breakpoint_five,
    // instruction writeback
    input  wire logic                  dest_write,
    input  wire logic [7:0]            dest_addr,
    input  wire logic [15:0]           dest_data,
    // results
    output logic                       breakpoint_enable,
    output logic                       register_break_select,
    output logic      [3:0]            host_command,
    output logic                       host_cmd_valid,
    output logic                       transfer_flag,
    output logic      [1:0]            programming_source_select,
    output logic                       system_program_enable,
    output logic                       hit_four,
    output logic                       hit_five
);
    logic [DATA_WIDTH-1:0] scratch0_q;
    logic [DATA_WIDTH-1:0] scratch0_d;
    logic [DATA_WIDTH-1:0] scratch1_q;
    logic [DATA_WIDTH-1:0] scratch1_d;
    logic [7:0]            control_q;
    logic [7:0]            control_d;
    logic [7:0]            flags_q;
    logic [7:0]            flags_d;
    logic [7:0]            buffer_q;
    logic [7:0]            buffer_d;
    logic                  tap_rst_meta_q;
    logic                  tap_rst_q;
    logic                  stop_meta_q;
    logic                  stop_q;
    logic                  xfer_done;
    logic                  run;
    logic                  sel;
    logic                  hit_s0;
    logic                  hit_s1;
    logic                  hit_ctl;
    logic                  hit_flg;
    logic                  hit_buf;
    logic                  scratch_open;
    logic                  wr_s0;
    logic                  wr_s1;
    logic                  wr_flg;
    logic                  wr_buf;
    logic [7:0]            ctl_keep;
    logic [7:0]            ctl_new;
    logic [7:0]            ctl_wmask;
    logic [7:0]            flag_cpu;
    logic [7:0]            rd_byte;
    logic [DATA_WIDTH-1:0] rd_word;
    logic [DATA_WIDTH-1:0] rdata_d;
    logic [DATA_WIDTH-1:0] rdata_q;
    logic                  cmd_known;
    logic                  cmd_valid_q;

    // tap reset and stop arrive from other domains; two flops first
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tap_rst_meta_q <= 1'b0;
            tap_rst_q      <= 1'b0;
            stop_meta_q    <= 1'b0;
            stop_q         <= 1'b0;
        end else begin
            tap_rst_meta_q <= tap_reset;
            tap_rst_q      <= tap_rst_meta_q;
            stop_meta_q    <= stop_mode;
            stop_q         <= stop_meta_q;
        end
    end

    xfer_sync u_xfer_sync (
        .mclk       (mclk),
        .resetn     (resetn),
        .toggle_in  (tap_xfer_toggle),
        .done_pulse (xfer_done)
    );

    // engine frozen in stop mode; clock gating itself lives outside
    assign run = ~stop_q;

    // module/index decode
    assign sel     = (cpu_module == `DBG_MODULE);
    assign hit_s0  = sel & (cpu_index == `DBG_IDX_SCRATCH0);
    assign hit_s1  = sel & (cpu_index == `DBG_IDX_SCRATCH1);
    assign hit_ctl = sel & (cpu_index == `DBG_IDX_CONTROL);
    assign hit_flg = sel & (cpu_index == `DBG_IDX_FLAGS);
    assign hit_buf = sel & (cpu_index == `DBG_IDX_BUFFER);

    assign scratch_open = background_mode | debug_mode;
    assign wr_s0  = cpu_write & hit_s0 & scratch_open;
    assign wr_s1  = cpu_write & hit_s1 & scratch_open;
    assign wr_flg = cpu_write & hit_flg;
    assign wr_buf = cpu_write & hit_buf;

    assign scratch0_d = wr_s0 ? cpu_wdata : scratch0_q;
    assign scratch1_d = wr_s1 ? cpu_wdata : scratch1_q;

    // control: cpu writes never reach it; engine writes only
    // breakpoint enable is frozen outside debug mode
    assign ctl_wmask = debug_mode ? `DBG_CTL_WMASK
                                  : (`DBG_CTL_WMASK & 8'h7f);
    assign ctl_new   = (eng_ctl_data & ctl_wmask)
                     | (control_q & ~ctl_wmask);
    assign ctl_keep  = eng_ctl_write ? ctl_new : control_q;
    // the command field follows the byte the host left in the buffer
    assign control_d = (eng_cmd_load && debug_mode)
        ? {ctl_keep[7:4], buffer_q[3:0]}
        : ctl_keep;

    // command decode straight off the buffer byte
    assign cmd_known = (buffer_q[7:4] == 4'h0) &&
        ((buffer_q[3:0] <= 4'(dbg_pkg::cmd_single_stp)) ||
         (buffer_q[3:0] == 4'(dbg_pkg::cmd_unlock)) ||
         (buffer_q[3:0] == 4'(dbg_pkg::cmd_read_reg)));

    // flags: cpu or engine may write; reserved bits dropped
    assign flag_cpu = (cpu_wdata[7:0] & `DBG_FLG_WMASK);
    always_comb begin
        flags_d = flags_q;
        if (eng_flag_write) begin
            flags_d = eng_flag_data & `DBG_FLG_WMASK;
        end
        if (wr_flg) begin
            flags_d = flag_cpu;
            // writing the transfer bit also drops source select
            flags_d[`DBG_FLG_PSS_MSB:`DBG_FLG_PSS_LSB] = 2'b00;
        end
        if (eng_xfer_clear) begin
            flags_d[`DBG_FLG_XFER_BIT] = 1'b0;
        end
        // a finishing scan wins over an engine clear or cpu write in the same cycle
        if (xfer_done) begin
            flags_d[`DBG_FLG_XFER_BIT] = 1'b1;
        end
    end

    // buffer: a finished scan loads the shift byte, beating cpu and engine
    assign buffer_d = xfer_done ? tap_shift_in
                    : wr_buf ? cpu_wdata[7:0]
                    : eng_buf_write ? eng_buf_data
                    : buffer_q;

    // one clocked block; tap test-logic-reset is a synchronous clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scratch0_q  <= `DBG_RESET_WORD;
            scratch1_q  <= `DBG_RESET_WORD;
            control_q   <= `DBG_RESET_BYTE;
            flags_q     <= `DBG_RESET_BYTE;
            buffer_q    <= `DBG_RESET_BYTE;
            cmd_valid_q <= 1'b0;
        end else if (tap_rst_q) begin
            scratch0_q  <= `DBG_RESET_WORD;
            scratch1_q  <= `DBG_RESET_WORD;
            control_q   <= `DBG_RESET_BYTE;
            flags_q     <= `DBG_RESET_BYTE;
            buffer_q    <= `DBG_RESET_BYTE;
            cmd_valid_q <= 1'b0;
        end else if (run) begin
            scratch0_q  <= scratch0_d;
            scratch1_q  <= scratch1_d;
            control_q   <= control_d;
            flags_q     <= flags_d;
            buffer_q    <= buffer_d;
            cmd_valid_q <= cmd_known;
        end
    end

    // read mux; blocked scratch reads give zero
    assign rd_byte = hit_ctl ? (control_q & `DBG_CTL_WMASK)
                   : hit_flg ? (flags_q & `DBG_FLG_WMASK)
                   : hit_buf ? buffer_q
                   : 8'h00;
    assign rd_word = (hit_s0 & scratch_open) ? scratch0_q
                   : (hit_s1 & scratch_open) ? scratch1_q
                   : {{(DATA_WIDTH-8){1'b0}}, rd_byte};
    assign rdata_d = cpu_read ? rd_word : '0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    break_match #(
        .WIDTH (16)
    ) u_break_match (
        .mclk                   (mclk),
        .resetn                 (resetn),
        .tap_reset              (tap_rst_q),
        .breakpoint_enable      (control_q[`DBG_CTL_BPEN_BIT]),
        .register_break_select  (control_q[`DBG_CTL_REGBRK_BIT]),
        .dest_write             (dest_write & run),
        .dest_addr              (dest_addr),
        .dest_data              (dest_data),
        .breakpoint_four        (breakpoint_four),
        .breakpoint_five        (breakpoint_five),
        .break_mask_register    (break_mask_register),
        .break_compare_register (break_compare_register),
        .hit_four               (hit_four),
        .hit_five               (hit_five)
    );

    assign cpu_rdata                 = rdata_q;
    assign tap_shift_out             = buffer_q;
    assign breakpoint_enable         = control_q[`DBG_CTL_BPEN_BIT];
    assign register_break_select     = control_q[`DBG_CTL_REGBRK_BIT];
    assign host_command              = control_q[`DBG_CTL_CMD_MSB:0];
    assign host_cmd_valid            = cmd_valid_q;
    assign transfer_flag             = flags_q[`DBG_FLG_XFER_BIT];
    assign programming_source_select =
        flags_q[`DBG_FLG_PSS_MSB:`DBG_FLG_PSS_LSB];
    assign system_program_enable     = flags_q[`DBG_FLG_SPE_BIT];
endmodule : debug_engine_register_bank

// ===== dv/dbg_bank_chk.sv
// dbg_bank_chk: port-level assertions for the debug register bank.
// assumes: bound to debug_engine_register_bank with 16-bit data.
`timescale 1ns/1ns
module dbg_bank_chk (
    // clock and reset
    input logic        mclk,
    input logic        resetn,
    input logic        tap_reset,
    // cpu side
    input logic [3:0]  cpu_module,
    input logic [4:0]  cpu_index,
    input logic        cpu_read,
    input logic        cpu_write,
    input logic [15:0] cpu_rdata,
    input logic        background_mode,
    input logic        debug_mode,
    // tap and engine side
    input logic        tap_xfer_toggle,
    input logic        eng_ctl_write,
    input logic        eng_cmd_load,
    input logic [15:0] break_mask_register,
    input logic [15:0] break_compare_register,
    input logic [7:0]  breakpoint_four,
    input logic [7:0]  breakpoint_five,
    input logic        dest_write,
    input logic [7:0]  dest_addr,
    input logic [15:0] dest_data,
    // results
    input logic        breakpoint_enable,
    input logic        register_break_select,
    input logic [3:0]  host_command,
    input logic        transfer_flag,
    input logic        hit_four,
    input logic        hit_five
);
    wire sel    = cpu_module == 4'h2;
    wire rd_scr = cpu_read && sel && cpu_index[4:1] == 4'hc
                  && !(background_mode || debug_mode);
    wire m5     = ((dest_data ^ break_compare_register)
                  & break_mask_register) == 16'h0000;
    wire arm    = breakpoint_enable && register_break_select && dest_write;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn || tap_reset);

    property p_scr_block;
        rd_scr |=> cpu_rdata == '0;
    endproperty
    a_scr_block: assert property (p_scr_block)
        else $error("blocked scratch read returned data");
    property p_ctl_rsv;
        cpu_read && sel && cpu_index == 5'h1a |=>
            cpu_rdata[15:8] == 8'h00 && !cpu_rdata[6] && !cpu_rdata[4];
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv)
        else $error("control reserved bits not zero");
    property p_flg_rsv;
        cpu_read && sel && cpu_index == 5'h1b |=> cpu_rdata[15:4] == 12'h000;
    endproperty
    a_flg_rsv: assert property (p_flg_rsv)
        else $error("flag reserved bits not zero");
    property p_bpen;
        !debug_mode |=> $stable(breakpoint_enable);
    endproperty
    a_bpen: assert property (p_bpen)
        else $error("breakpoint enable moved outside debug mode");
    property p_cpu_ctl;
        cpu_write && sel && cpu_index == 5'h1a && !eng_ctl_write
            && !eng_cmd_load |=> $stable({breakpoint_enable,
            register_break_select, host_command});
    endproperty
    a_cpu_ctl: assert property (p_cpu_ctl)
        else $error("cpu write changed control");
    property p_no_hit;
        !breakpoint_enable |=> !hit_four && !hit_five;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("hit while breakpoints disabled");
    property p_bp4;
        arm && dest_addr == breakpoint_four |=> hit_four;
    endproperty
    a_bp4: assert property (p_bp4)
        else $error("register break four missed");
    property p_bp5;
        arm && dest_addr == breakpoint_five |=> hit_five == $past(m5);
    endproperty
    a_bp5: assert property (p_bp5)
        else $error("register break five wrong");
    property p_xfer;
        $changed(tap_xfer_toggle) |-> ##[1:4] transfer_flag;
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("transfer flag not set after scan");
    property p_tlr;
        disable iff (!resetn)
        tap_reset [*5] |-> !breakpoint_enable && !register_break_select
            && host_command == 4'h0 && !transfer_flag;
    endproperty
    a_tlr: assert property (p_tlr)
        else $error("test-logic-reset left state");

    c_bp4:  cover property (hit_four);
    c_bp5:  cover property (hit_five);
    c_xfer: cover property ($rose(transfer_flag));
endmodule : dbg_bank_chk

// ===== dv/tap_model.sv
// tap_model: far side of the tap link, one byte per scan.
// assumes: the bench calls scan().
`timescale 1ns/1ns
module tap_model (
    // link to the bank
    output logic       tap_xfer_toggle,
    output logic [7:0] tap_shift_in
);
    initial begin
        tap_xfer_toggle = 1'b0;
        tap_shift_in    = 8'h00;
    end
    // byte inverts after the hold so a late sample shows
    task automatic scan(input logic [7:0] b);
        tap_shift_in = b;
        #17;
        tap_xfer_toggle = ~tap_xfer_toggle;
        #53;
        tap_shift_in = ~b;
        #13;
    endtask : scan
endmodule : tap_model

// ===== dv/testbench.sv
// testbench: drives the debug bank from cpu, engine and tap.
// assumes: design, checker and tap_model compiled first.
`timescale 1ns/1ns
module testbench;
    logic        mclk, resetn, stop_mode, cpu_read, cpu_write, rd_prev;
    logic [3:0]  cpu_module, host_command;
    logic [4:0]  cpu_index;
    logic [15:0] cpu_wdata, cpu_rdata, dest_data, d0, d1;
    logic [15:0] break_mask_register, break_compare_register;
    logic        background_mode, debug_mode, tap_reset, tap_xfer_toggle;
    logic [7:0]  tap_shift_in, tap_shift_out, eng_ctl_data, eng_flag_data;
    logic [7:0]  eng_buf_data, breakpoint_four, breakpoint_five, dest_addr, b;
    logic        eng_ctl_write, eng_cmd_load, eng_xfer_clear, eng_flag_write;
    logic        eng_buf_write, dest_write, breakpoint_enable, hit_four;
    logic        register_break_select, host_cmd_valid, transfer_flag;
    logic        system_program_enable, hit_five;
    logic [1:0]  programming_source_select;
    logic [15:0] expq [$];
    logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                               4'h8, 4'h9};
    int          num_errors = 0;
    int          num_checks = 0;
    int          seed = 80;

    debug_engine_register_bank dut (.mclk, .resetn,
        .stop_mode, .cpu_module, .cpu_index, .cpu_read, .cpu_write,
        .cpu_wdata, .cpu_rdata, .background_mode, .debug_mode, .tap_reset,
        .tap_xfer_toggle, .tap_shift_in, .tap_shift_out, .eng_ctl_write,
        .eng_ctl_data, .eng_cmd_load, .eng_xfer_clear, .eng_flag_write,
        .eng_flag_data, .eng_buf_write, .eng_buf_data, .break_mask_register,
        .break_compare_register, .breakpoint_four, .breakpoint_five,
        .dest_write, .dest_addr, .dest_data, .breakpoint_enable,
        .register_break_select, .host_command, .host_cmd_valid,
        .transfer_flag, .programming_source_select, .system_program_enable,
        .hit_four, .hit_five);
    tap_model tap (.tap_xfer_toggle, .tap_shift_in);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic acc(input logic w, input logic [3:0] m,
                       input logic [4:0] idx, input logic [15:0] d);
        @(negedge mclk);
        cpu_module = m;
        cpu_index = idx;
        cpu_wdata = d;
        cpu_write = w;
        cpu_read = !w;
        @(negedge mclk);
        cpu_write = 1'b0;
        cpu_read = 1'b0;
    endtask : acc

    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        acc(1'b1, 4'h2, idx, d);
    endtask : wr

    task automatic rd(input logic [4:0] idx, input logic [15:0] e);
        expq.push_back(e);
        acc(1'b0, 4'h2, idx, 16'h0000);
    endtask : rd

    // k picks the strobe: ctl, cmd load, xfer clear, flags, buffer
    task automatic eng(input int k, input logic [7:0] d);
        @(negedge mclk);
        {eng_ctl_data, eng_flag_data, eng_buf_data} = {3{d}};
        {eng_ctl_write, eng_cmd_load, eng_xfer_clear, eng_flag_write,
            eng_buf_write} = 5'b10000 >> k;
        @(negedge mclk);
        {eng_ctl_write, eng_cmd_load, eng_xfer_clear, eng_flag_write,
            eng_buf_write} = 5'b00000;
    endtask : eng

    task automatic dest(input logic [7:0] a, input logic [15:0] d,
                        input logic h4, input logic h5);
        @(negedge mclk);
        dest_write = 1'b1;
        dest_addr = a;
        dest_data = d;
        @(negedge mclk);
        dest_write = 1'b0;
        check({15'h0, hit_four}, {15'h0, h4});
        check({15'h0, hit_five}, {15'h0, h5});
    endtask : dest

    // read data lands one cycle after the read edge
    always @(posedge mclk) rd_prev <= cpu_read;
    always @(negedge mclk) begin
        if (rd_prev === 1'b1 && expq.size() > 0)
            check(cpu_rdata, expq.pop_front());
    end

    // whole run is well under 2000 cycles
    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    initial begin
        {resetn, stop_mode, cpu_read, cpu_write, tap_reset} = '0;
        {background_mode, debug_mode, dest_write, eng_ctl_write} = '0;
        {eng_cmd_load, eng_xfer_clear, eng_flag_write, eng_buf_write} = '0;
        {cpu_module, cpu_index, cpu_wdata, dest_data, dest_addr} = '0;
        {eng_ctl_data, eng_flag_data, eng_buf_data} = '0;
        {break_mask_register, break_compare_register} = '0;
        {breakpoint_four, breakpoint_five} = '0;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        background_mode = 1'b1;
        for (int i = 24; i < 32; i++)
            rd(i[4:0], 16'h0000);
        expq.push_back(16'h0000);
        acc(1'b0, 4'h3, 5'h1c, 16'h0000);
        $display("reset test done");
        d0 = 16'($random(seed));
        d1 = 16'($random(seed));
        wr(5'h18, d0);
        wr(5'h19, d1);
        rd(5'h18, d0);
        rd(5'h19, d1);
        background_mode = 1'b0;
        rd(5'h18, 16'h0000);
        wr(5'h18, ~d0);
        wr(5'h19, ~d1);
        debug_mode = 1'b1;
        acc(1'b1, 4'h3, 5'h18, ~d0);
        rd(5'h18, d0);
        rd(5'h19, d1);
        $display("scratch test done");
        eng(0, 8'hff);
        rd(5'h1a, 16'h00af);
        check({10'h0, breakpoint_enable, register_break_select,
               host_command}, 16'h003f);
        wr(5'h1a, 16'h0000);
        rd(5'h1a, 16'h00af);
        debug_mode = 1'b0;
        eng(0, 8'h00);
        rd(5'h1a, 16'h0080);
        debug_mode = 1'b1;
        eng(0, 8'h00);
        rd(5'h1a, 16'h0000);
        $display("control test done");
        foreach (codes[i]) begin
            tap.scan({4'h0, codes[i]});
            check({15'h0, host_cmd_valid}, 16'h0001);
            eng(1, 8'h00);
            rd(5'h1a, {12'h000, codes[i]});
        end
        tap.scan(8'h07);
        check({15'h0, host_cmd_valid}, 16'h0000);
        tap.scan(8'h19);
        check({15'h0, host_cmd_valid}, 16'h0000);
        $display("command test done");
        eng(2, 8'h00);
        rd(5'h1b, 16'h0000);
        wr(5'h1b, 16'hffff);
        rd(5'h1b, 16'h0003);
        eng(3, 8'hfc);
        rd(5'h1b, 16'h000c);
        check({14'h0, programming_source_select}, 16'h0003);
        wr(5'h1b, 16'h0002);
        rd(5'h1b, 16'h0002);
        check({15'h0, system_program_enable}, 16'h0001);
        $display("flag test done");
        b = 8'($random(seed));
        tap.scan(b);
        check({15'h0, transfer_flag}, 16'h0001);
        rd(5'h1c, {8'h00, b});
        wr(5'h1c, {8'hff, ~b});
        rd(5'h1c, {8'h00, ~b});
        check({8'h00, tap_shift_out}, {8'h00, ~b});
        eng(4, b ^ 8'h5a);
        rd(5'h1c, {8'h00, b ^ 8'h5a});
        stop_mode = 1'b1;
        repeat (2) @(negedge mclk);
        wr(5'h1c, 16'h0000);
        stop_mode = 1'b0;
        rd(5'h1c, {8'h00, b ^ 8'h5a});
        $display("buffer test done");
        breakpoint_four = 8'h21;
        breakpoint_five = 8'h42;
        break_mask_register = 16'h0ff0;
        break_compare_register = 16'h0a50;
        eng(0, 8'h20);
        dest(8'h21, 16'h0000, 1'b0, 1'b0);
        eng(0, 8'ha0);
        dest(8'h21, 16'h0000, 1'b1, 1'b0);
        dest(8'h22, 16'h0000, 1'b0, 1'b0);
        dest(8'h42, 16'hfa5f, 1'b0, 1'b1);
        dest(8'h42, 16'h0a40, 1'b0, 1'b0);
        break_mask_register = 16'h0000;
        dest(8'h42, 16'($random(seed)), 1'b0, 1'b1);
        $display("breakpoint test done");
        tap_reset = 1'b1;
        repeat (6) @(negedge mclk);
        tap_reset = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 24; i < 29; i++)
            rd(i[4:0], 16'h0000);
        $display("tap reset test done");
        repeat (2) @(negedge mclk);
        summarize();
    end
endmodule : testbench

bind debug_engine_register_bank dbg_bank_chk
    u_chk (.mclk, .resetn, .tap_reset, .cpu_module, .cpu_index, .cpu_read,
    .cpu_write, .cpu_rdata, .background_mode, .debug_mode, .tap_xfer_toggle,
    .eng_ctl_write, .eng_cmd_load, .break_mask_register,
    .break_compare_register, .breakpoint_four, .breakpoint_five,
    .dest_write, .dest_addr, .dest_data, .breakpoint_enable,
    .register_break_select, .host_command, .transfer_flag, .hit_four,
    .hit_five);
